// file: rmp_host_model.sv
// host side register access model for the rest-mode bank
`timescale 1ns/1ps
module rmp_host_model (
	input  wire       core_clk_in,
	input  wire [7:0] rdata_in,
	output reg        wr_out,
	output reg        rd_out,
	output reg  [6:0] addr_out,
	output reg  [7:0] wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 7'h00;
		wdata_out = 8'h00;
	end
	task wr(input [6:0] a, input [7:0] v);
		begin
			@(negedge core_clk_in);
			addr_out = a;
			wdata_out = v;
			wr_out = 1'b1;
			@(negedge core_clk_in);
			wr_out = 1'b0;
			wdata_out = ~v;
		end
	endtask
	task rd(input [6:0] a, output [7:0] v);
		begin
			@(negedge core_clk_in);
			addr_out = a;
			rd_out = 1'b1;
			@(negedge core_clk_in);
			rd_out = 1'b0;
			@(negedge core_clk_in);
			v = rdata_in;
		end
	endtask
	task set_period(input [6:0] a, input [7:0] v);
		begin
			wr(7'h22, 8'h80);
			wr(a, v);
			wr(7'h22, 8'h00);
		end
	endtask
endmodule // rmp_host_model

// file: rmp_regs.vh
// register offsets, reset values and timing counts of the rest-mode / preflash bank
`ifndef RMP_REGS_VH
`define RMP_REGS_VH
`define RMP_ADDR_RUN_TO_REST      7'h0e
`define RMP_ADDR_FIRST_REST_FRAME_PERIOD     7'h0f
`define RMP_ADDR_FIRST_REST_MODE_EXIT       7'h10
`define RMP_ADDR_SECOND_REST_FRAME_PERIOD     7'h11
`define RMP_ADDR_SECOND_REST_MODE_EXIT       7'h12
`define RMP_ADDR_THIRD_REST_FRAME_PERIOD     7'h13
`define RMP_ADDR_PRESAT_NORMAL    7'h14
`define RMP_ADDR_PRESAT_DARK      7'h18
`define RMP_ADDR_MOTION_FLAGS     7'h1b
`define RMP_ADDR_NAV_CTRL         7'h22
`define RMP_RST_RUN_TO_REST       8'h46
`define RMP_RST_FIRST_REST_FRAME_PERIOD      8'h00
`define RMP_RST_FIRST_REST_MODE_EXIT        8'h4f
`define RMP_RST_SECOND_REST_FRAME_PERIOD      8'h09
`define RMP_RST_SECOND_REST_MODE_EXIT        8'h2f
`define RMP_RST_THIRD_REST_FRAME_PERIOD      8'h31
`define RMP_RST_PRESAT            8'h80
`define RMP_RST_NAV_CTRL          8'h80
`define RMP_BIT_AWAKE             7
`define RMP_BIT_PRESAT_SEL        7
`define RMP_BIT_MOTION            7
`define RMP_BIT_GRABBED_PIXEL_VALID          6
`define RMP_BIT_GRABBED_PIXEL_IS_ORIGIN          5
`define RMP_BIT_DY_OVF            4
`define RMP_BIT_DX_OVF            3
`define RMP_RUN_FRAMES_PER_UNIT   16
`define RMP_FIRST_REST_MODE_MULT            16
`define RMP_SECOND_REST_MODE_MULT            128
`define RMP_PERIOD_STEP_NS        7000000
`define RMP_CLK_PERIOD_NS         20
`define RMP_IDLE_MULT             64
`define RMP_PROC_MULT             32
`endif

// file: rmp_rest_ctrl.v
// rest-mode downshift, rest frame pacing, led preflash timing and their registers
// Notes on behaviour
// - run exits after delay times 16 frames
// - rest period is (value+1) times 7 ms
// - first_rest_mode exit after value*period1*16
// - second_rest_mode exit after value*period2*128
// - awake bit set disables rest modes
// - led lit before shutter opens
// - bit 7 selects idle or processing preflash
// - idle preflash lasts field times 64 clocks
// - processing preflash is proc-32*field+idle
// - dark surface uses its own preflash register
// - dark field too large gives idle time
// - read-only extended motion status register
// - bit 5 first pixel, bit 7 motion
`timescale 1ns/1ps
`include "rmp_regs.vh"
module rmp_rest_ctrl #(
	parameter PROC_CLKS = 3520,
	parameter IDLE_CLKS = 1000
) (
	input  wire       core_clk_in,
	input  wire       rst_b_in,
	input  wire       reg_wr_in,
	input  wire       reg_rd_in,
	input  wire [6:0] reg_addr_in,
	input  wire [7:0] reg_wdata_in,
	input  wire       frame_done_in,
	input  wire       motion_in,
	input  wire       dark_surface_in,
	input  wire       grabbed_pixel_valid_in,
	input  wire       grabbed_pixel_is_origin_in,
	input  wire       dy_ovf_in,
	input  wire       dx_ovf_in,
	output reg  [7:0] reg_rdata_out,
	output reg  [1:0] mode_out,
	output reg        frame_start_out,
	output reg        led_out,
	output reg        shutter_open_out
);
	localparam ST_RUN   = 2'd0;
	localparam ST_FIRST_REST_MODE = 2'd1;
	localparam ST_SECOND_REST_MODE = 2'd2;
	localparam ST_THIRD_REST_MODE = 2'd3;
	localparam P_IDLE   = 2'd0;
	localparam P_FLASH  = 2'd1;
	localparam P_EXPOSE = 2'd2;
	localparam [31:0] STEP_CLKS = `RMP_PERIOD_STEP_NS / `RMP_CLK_PERIOD_NS;
	localparam [31:0] PROC_32 = PROC_CLKS;
	localparam [31:0] IDLE_32 = IDLE_CLKS;
	localparam [31:0] DARK_32 = PROC_CLKS / `RMP_PROC_MULT;
	localparam [15:0] PROC_W = PROC_32[15:0];
	localparam [15:0] IDLE_W = IDLE_32[15:0];
	localparam [15:0] DARK_LIMIT = DARK_32[15:0];

	reg [7:0] run_delay_q, p1_q, d1_q, p2_q, d2_q, p3_q, pre_n_q, pre_d_q, nav_q;
	reg [7:0] motion_flags_q;
	reg [1:0] mode_q;
	reg [7:0] frame_unit_q;
	reg [3:0] frame_sub_q;
	// one 7 ms step is 350000 clocks, needs 19 bits
	reg [18:0] step_q;
	reg [7:0] per_cnt_q;
	reg [1:0] pst_q;
	reg [15:0] pcnt_q;
	reg        load_q;
	reg [7:0]  cur_period;
	reg [23:0] exit_count;
	reg [15:0] pre_len;
	reg [7:0]  pre_sel;
	wire       exit_done;
	wire       step_tick = (step_q == STEP_CLKS[18:0] - 19'd1);
	wire       rest_ok   = ~nav_q[`RMP_BIT_AWAKE];
	wire       period_tick = step_tick && (per_cnt_q == cur_period);

	always @* begin
		case (mode_q)
			ST_FIRST_REST_MODE: cur_period = p1_q;
			ST_SECOND_REST_MODE: cur_period = p2_q;
			default:  cur_period = p3_q;
		endcase
	end

	always @* begin
		case (mode_q)
			ST_FIRST_REST_MODE: exit_count = {12'h000, d1_q, 4'h0};
			ST_SECOND_REST_MODE: exit_count = {9'h000, d2_q, 7'h00};
			default:  exit_count = 24'd0;
		endcase
	end

	// counts rest frames down from exit_count; pulses exit_done after that many
	rmp_timer #(.W(24)) u_exit (
		.core_clk_in (core_clk_in),
		.rst_b_in    (rst_b_in),
		.load_in     (load_q),
		.count_in    (exit_count),
		.tick_in     (period_tick),
		.done_out    (exit_done)
	);

	always @* begin
		pre_sel = dark_surface_in ? pre_n_q : pre_n_q;
		if (dark_surface_in)
			pre_sel = pre_d_q;
		if (!pre_sel[`RMP_BIT_PRESAT_SEL])
			pre_len = {3'b000, pre_sel[6:0], 6'b000000};
		else if (dark_surface_in && ({9'h000, pre_sel[6:0]} > DARK_LIMIT))
			pre_len = IDLE_W;
		else
			pre_len = PROC_W - {4'h0, pre_sel[6:0], 5'b00000} + IDLE_W;
	end

	always @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			run_delay_q    <= `RMP_RST_RUN_TO_REST;
			p1_q           <= `RMP_RST_FIRST_REST_FRAME_PERIOD;
			d1_q           <= `RMP_RST_FIRST_REST_MODE_EXIT;
			p2_q           <= `RMP_RST_SECOND_REST_FRAME_PERIOD;
			d2_q           <= `RMP_RST_SECOND_REST_MODE_EXIT;
			p3_q           <= `RMP_RST_THIRD_REST_FRAME_PERIOD;
			pre_n_q        <= `RMP_RST_PRESAT;
			pre_d_q        <= `RMP_RST_PRESAT;
			nav_q          <= `RMP_RST_NAV_CTRL;
			reg_rdata_out  <= 8'h00;
			motion_flags_q <= 8'h00;
		end else begin
			if (reg_wr_in) begin
				case (reg_addr_in)
					`RMP_ADDR_RUN_TO_REST:   run_delay_q <= reg_wdata_in;
					`RMP_ADDR_FIRST_REST_FRAME_PERIOD:  p1_q <= reg_wdata_in;
					`RMP_ADDR_FIRST_REST_MODE_EXIT:    d1_q <= reg_wdata_in;
					`RMP_ADDR_SECOND_REST_FRAME_PERIOD:  p2_q <= reg_wdata_in;
					`RMP_ADDR_SECOND_REST_MODE_EXIT:    d2_q <= reg_wdata_in;
					`RMP_ADDR_THIRD_REST_FRAME_PERIOD:  p3_q <= reg_wdata_in;
					`RMP_ADDR_PRESAT_NORMAL: pre_n_q <= reg_wdata_in;
					`RMP_ADDR_PRESAT_DARK:   pre_d_q <= reg_wdata_in;
					`RMP_ADDR_NAV_CTRL:      nav_q <= {reg_wdata_in[7], 7'h00};
					default:                 nav_q <= nav_q;
				endcase
			end
			// status sampled per frame; read clears motion, set wins
			if (frame_done_in)
				motion_flags_q <= {motion_in | motion_flags_q[7], grabbed_pixel_valid_in, grabbed_pixel_is_origin_in,
					dy_ovf_in, dx_ovf_in, 3'b000};
			else if (reg_rd_in && reg_addr_in == `RMP_ADDR_MOTION_FLAGS)
				motion_flags_q[`RMP_BIT_MOTION] <= 1'b0;
			if (reg_rd_in) begin
				case (reg_addr_in)
					`RMP_ADDR_RUN_TO_REST:   reg_rdata_out <= run_delay_q;
					`RMP_ADDR_FIRST_REST_FRAME_PERIOD:  reg_rdata_out <= p1_q;
					`RMP_ADDR_FIRST_REST_MODE_EXIT:    reg_rdata_out <= d1_q;
					`RMP_ADDR_SECOND_REST_FRAME_PERIOD:  reg_rdata_out <= p2_q;
					`RMP_ADDR_SECOND_REST_MODE_EXIT:    reg_rdata_out <= d2_q;
					`RMP_ADDR_THIRD_REST_FRAME_PERIOD:  reg_rdata_out <= p3_q;
					`RMP_ADDR_PRESAT_NORMAL: reg_rdata_out <= pre_n_q;
					`RMP_ADDR_PRESAT_DARK:   reg_rdata_out <= pre_d_q;
					`RMP_ADDR_MOTION_FLAGS:  reg_rdata_out <= motion_flags_q;
					`RMP_ADDR_NAV_CTRL:      reg_rdata_out <= nav_q;
					default:                 reg_rdata_out <= 8'h00;
				endcase
			end
		end
	end

	// mode machine
	always @(posedge core_clk_in) begin
		load_q <= 1'b0;
		if (!rst_b_in) begin
			mode_q       <= ST_RUN;
			mode_out     <= ST_RUN;
			frame_unit_q <= 8'h00;
			frame_sub_q  <= 4'h0;
		end else begin
			// mode_out tracks mode_q edge for edge so a wake shows next cycle
			case (mode_q)
				ST_RUN: begin
					if (motion_in || !rest_ok) begin
						frame_unit_q <= 8'h00;
						frame_sub_q  <= 4'h0;
					end else if (frame_done_in) begin
						frame_sub_q <= frame_sub_q + 4'h1;
						if (frame_sub_q == 4'hf) begin
							if (frame_unit_q + 8'h01 >= run_delay_q) begin
								mode_q   <= ST_FIRST_REST_MODE;
								mode_out <= ST_FIRST_REST_MODE;
								load_q   <= 1'b1;
							end
							frame_unit_q <= frame_unit_q + 8'h01;
						end
					end
				end
				ST_FIRST_REST_MODE, ST_SECOND_REST_MODE, ST_THIRD_REST_MODE: begin
					if (motion_in || !rest_ok) begin
						mode_q       <= ST_RUN;
						mode_out     <= ST_RUN;
						frame_unit_q <= 8'h00;
						frame_sub_q  <= 4'h0;
					end else if (exit_done && mode_q != ST_THIRD_REST_MODE) begin
						mode_q   <= mode_q + 2'd1;
						mode_out <= mode_q + 2'd1;
						load_q   <= (mode_q == ST_FIRST_REST_MODE);
					end
				end
				default: begin
					mode_q   <= ST_RUN;
					mode_out <= ST_RUN;
				end
			endcase
		end
	end

	// rest frame pacing in 7 ms steps
	always @(posedge core_clk_in) begin
		frame_start_out <= 1'b0;
		if (!rst_b_in || mode_q == ST_RUN) begin
			step_q    <= 18'd0;
			per_cnt_q <= 8'h00;
			// single-cycle request: idle fsm still reads idle on the take edge
			if (rst_b_in && pst_q == P_IDLE && !frame_start_out)
				frame_start_out <= 1'b1;
		end else if (step_tick) begin
			step_q <= 18'd0;
			if (period_tick) begin
				per_cnt_q       <= 8'h00;
				frame_start_out <= 1'b1;
			end else
				per_cnt_q <= per_cnt_q + 8'h01;
		end else
			step_q <= step_q + 18'd1;
	end

	// led lit for preflash, then shutter opens
	always @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pst_q            <= P_IDLE;
			pcnt_q           <= 16'h0000;
			led_out          <= 1'b0;
			shutter_open_out <= 1'b0;
		end else begin
			case (pst_q)
				P_IDLE: if (frame_start_out) begin
					pst_q   <= P_FLASH;
					pcnt_q  <= pre_len;
					led_out <= 1'b1;
				end
				P_FLASH: if (pcnt_q <= 16'h0001) begin
					pst_q            <= P_EXPOSE;
					shutter_open_out <= 1'b1;
				end else
					pcnt_q <= pcnt_q - 16'h0001;
				P_EXPOSE: if (frame_done_in) begin
					pst_q            <= P_IDLE;
					led_out          <= 1'b0;
					shutter_open_out <= 1'b0;
				end
				default: pst_q <= P_IDLE;
			endcase
		end
	end
endmodule // rmp_rest_ctrl

// file: rmp_rest_ctrl_sva.sv
// port assertions for the rest-mode and preflash bank
`timescale 1ns/1ps
module rmp_rest_ctrl_sva (
	input wire       core_clk_in,
	input wire       rst_b_in,
	input wire       reg_rd_in,
	input wire [6:0] reg_addr_in,
	input wire       frame_done_in,
	input wire       motion_in,
	input wire [7:0] reg_rdata_out,
	input wire [1:0] mode_out,
	input wire       frame_start_out,
	input wire       led_out,
	input wire       shutter_open_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_flag_rd;
		reg_rd_in && reg_addr_in == 7'h1b && !frame_done_in;
	endsequence
	sequence s_two_rd;
		s_flag_rd ##1 (!frame_done_in)[*2] ##1 s_flag_rd;
	endsequence
	a_motion_wakes: assert property (motion_in |=> mode_out == 2'h0) else $error("motion kept rest");
	a_shut_led: assert property (shutter_open_out |-> led_out) else $error("shutter without led");
	a_mode_step: assert property ($changed(mode_out) |-> mode_out == 2'h0 ||
		mode_out == $past(mode_out) + 2'h1) else $error("mode skipped");
	a_rsvd_zero: assert property (s_flag_rd |=> reg_rdata_out[2:0] == 3'h0) else $error("rsvd set");
	a_unmap_zero: assert property (reg_rd_in && reg_addr_in == 7'h7f |=> reg_rdata_out == 8'h00)
		else $error("unmapped data");
	a_rd_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("rdata moved");
	a_motion_clear: assert property (s_two_rd |=> !reg_rdata_out[7]) else $error("motion stuck");
	a_frame_pulse: assert property (frame_start_out |=> !frame_start_out) else $error("long start");
endmodule // rmp_rest_ctrl_sva
bind rmp_rest_ctrl rmp_rest_ctrl_sva u_sva (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
	.reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .frame_done_in(frame_done_in), .motion_in(motion_in),
	.reg_rdata_out(reg_rdata_out), .mode_out(mode_out), .frame_start_out(frame_start_out),
	.led_out(led_out), .shutter_open_out(shutter_open_out));

// file: rmp_rest_ctrl_tb.sv
// self-checking bench for the rest-mode and preflash bank
`timescale 1ns/1ps
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin failures = failures + 1; \
	$display("BAD %0t got %0h want %0h", $time, a, b); end end
module rmp_rest_ctrl_tb;
	reg         clk = 1'b0;
	reg         rst_b = 1'b0;
	reg         fdone = 1'b0;
	reg         motion = 1'b0;
	reg         dark = 1'b0;
	reg  [3:0]  st = 4'h0;
	wire        wr, rd, fs, led, shut;
	wire [6:0]  addr;
	wire [7:0]  wdata, rdata;
	wire [1:0]  mode;
	reg  [7:0]  d;
	integer     failures = 0, compares = 0, n, i;
	localparam [79:0] RA = 80'h0e0f1011121314181b22;
	localparam [79:0] RV = 80'h46004f092f3180800080;
	always #10 clk = ~clk;
	rmp_host_model host (.core_clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
		.addr_out(addr), .wdata_out(wdata));
	rmp_rest_ctrl dut (.core_clk_in(clk), .rst_b_in(rst_b), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .frame_done_in(fdone), .motion_in(motion),
		.dark_surface_in(dark), .grabbed_pixel_valid_in(st[3]), .grabbed_pixel_is_origin_in(st[2]), .dy_ovf_in(st[1]),
		.dx_ovf_in(st[0]), .reg_rdata_out(rdata), .mode_out(mode), .frame_start_out(fs),
		.led_out(led), .shutter_open_out(shut));
	task frame;
		begin
			n = 0;
			while (shut !== 1'b1 && n < 9000) begin
				@(negedge clk);
				n = n + 1;
			end
			fdone = 1'b1;
			@(negedge clk);
			fdone = 1'b0;
		end
	endtask
	task measure(input [6:0] a, input [7:0] v, input integer want);
		begin
			host.wr(a, v);
			frame();
			for (i = 0; i < 50 && led !== 1'b1; i = i + 1)
				@(negedge clk);
			frame();
			`CHK(n, want)
		end
	endtask
	task to_rest;
		begin
			motion = 1'b1;
			frame();
			motion = 1'b0;
			for (i = 0; i < 1200 && mode !== 2'h1; i = i + 1)
				frame();
			`CHK(i, 1120)
		end
	endtask
	task t_reset;
		begin
			for (i = 0; i < 10; i = i + 1) begin
				host.rd(RA[78 - 8 * i -: 7], d);
				`CHK(d, RV[79 - 8 * i -: 8])
			end
			host.rd(7'h7f, d);
			`CHK(d, 8'h00)
			$display("t_reset done");
		end
	endtask
	task t_access;
		begin
			host.wr(7'h1b, 8'hff);
			host.rd(7'h1b, d);
			`CHK(d, 8'h00)
			host.wr(7'h22, 8'h7f);
			host.rd(7'h22, d);
			`CHK(d, 8'h00)
			host.set_period(7'h13, 8'hfd);
			host.rd(7'h13, d);
			`CHK(d, 8'hfd)
			host.wr(7'h22, 8'h80);
			$display("t_access done");
		end
	endtask
	task t_preflash;
		begin
			measure(7'h14, 8'h05, 320);
			measure(7'h14, 8'h85, 4360);
			dark = 1'b1;
			measure(7'h18, 8'h83, 4424);
			measure(7'h18, 8'hff, 1000);
			dark = 1'b0;
			$display("t_preflash done");
		end
	endtask
	task t_flags;
		begin
			st = 4'hf;
			motion = 1'b1;
			frame();
			motion = 1'b0;
			host.rd(7'h1b, d);
			`CHK(d, 8'hf8)
			host.rd(7'h1b, d);
			`CHK(d, 8'h78)
			st = 4'h4;
			frame();
			host.rd(7'h1b, d);
			`CHK(d, 8'h20)
			$display("t_flags done");
		end
	endtask
	task t_downshift;
		begin
			host.wr(7'h14, 8'h00);
			for (i = 0; i < 1130; i = i + 1)
				frame();
			`CHK(mode, 2'h0)
			host.wr(7'h22, 8'h00);
			to_rest();
			host.set_period(7'h0f, 8'h01);
			`CHK(mode, 2'h0)
			to_rest();
			motion = 1'b1;
			repeat (2) @(negedge clk);
			motion = 1'b0;
			`CHK(mode, 2'h0)
			$display("t_downshift done");
		end
	endtask
	task conclude;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		// tests need about 1 ms; margin kept under 100k cycles
		#1800000;
		failures = failures + 1;
		conclude();
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		t_reset();
		t_access();
		t_preflash();
		t_flags();
		t_downshift();
		conclude();
	end
endmodule // rmp_rest_ctrl_tb

// file: rmp_timer.v
// down-counter that times one interval and pulses on expiry
`timescale 1ns/1ps
module rmp_timer #(
	parameter W = 24
) (
	input  wire         core_clk_in,
	input  wire         rst_b_in,
	input  wire         load_in,
	input  wire [W-1:0] count_in,
	input  wire         tick_in,
	output reg          done_out
);
	reg [W-1:0] cnt_q;
	reg         run_q;
	always @(posedge core_clk_in) begin
		done_out <= 1'b0;
		if (!rst_b_in) begin
			cnt_q <= {W{1'b0}};
			run_q <= 1'b0;
		end else if (load_in) begin
			cnt_q <= count_in;
			run_q <= 1'b1;
		end else if (run_q && tick_in) begin
			if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
				run_q    <= 1'b0;
				done_out <= 1'b1;
			end else begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // rmp_timer
